// >>> mpu_defs.svh
/*
 * Register offsets, field positions, reset values and timing counts for the motor
 * update-and-timer block. Assumes inclusion by bare name from the block's files.
 */
`ifndef MPU_DEFS_SVH
`define MPU_DEFS_SVH

`define MPU_ADDR_W          5
`define MPU_OFS_TIM         5'h00
`define MPU_OFS_TIML        5'h01
`define MPU_OFS_ZPRV        5'h02
`define MPU_OFS_ZREG        5'h03
`define MPU_OFS_COMP        5'h04
`define MPU_OFS_DREG        5'h05
`define MPU_OFS_WGHT        5'h06
`define MPU_OFS_ISR         5'h07
`define MPU_OFS_IMR         5'h08
`define MPU_OFS_CTRL        5'h09
`define MPU_OFS_REP         5'h0a
`define MPU_OFS_PCR         5'h0b
`define MPU_OFS_CMP0L       5'h0c
`define MPU_OFS_CMP0H       5'h0d
`define MPU_OFS_CMPUL       5'h0e
`define MPU_OFS_CMPUH       5'h0f
`define MPU_OFS_CMPVL       5'h10
`define MPU_OFS_CMPVH       5'h11
`define MPU_OFS_CMPWL       5'h12
`define MPU_OFS_CMPWH       5'h13
`define MPU_OFS_ISR2        5'h14
`define MPU_OFS_PWMCNTL     5'h15
`define MPU_OFS_PWMCNTH     5'h16

`define MPU_ISR_UPDATE      7
`define MPU_ISR_RINC        6
`define MPU_ISR_RDEC        5
`define MPU_ISR_CURRENT_LIMIT_ENABLE        4
`define MPU_ISR_ESTOP       3
`define MPU_ISR_ZC          2
`define MPU_ISR_DEMAG       1
`define MPU_ISR_COMM        0
`define MPU_ISR2_SPEED      0
`define MPU_ISR2_SOUT       1
`define MPU_IMR_UPDATE      7
`define MPU_IMR_SPEED       6
`define MPU_IMR_RATIO       5
`define MPU_IMR_CURRENT_LIMIT_ENABLE        4
`define MPU_IMR_ESTOP       3
`define MPU_IMR_ZC          2
`define MPU_IMR_DEMAG       1
`define MPU_IMR_COMM        0

`define MPU_CTRL_CKE        0
`define MPU_CTRL_SWA        1
`define MPU_CTRL_DCB        2
`define MPU_CTRL_SPEED      3
`define MPU_CTRL_SWCAP      4
`define MPU_CTRL_SOUT_EN    5

`define MPU_RESYNC_VALUE    8'hff
`define MPU_RESET_BYTE      8'h00
`define MPU_RESET_CNT       12'h000
`define MPU_CNT_W           12

`endif

// >>> mpu_pkg.sv
/*
 * Types shared by the motor update-and-timer block. Assumes the _defs header
 * for all numeric constants.
 */
package mpu_pkg;
    typedef enum logic [1:0] {
        MPU_STOPPED,
        MPU_START,
        MPU_RUN
    } mpu_run_t;

    typedef struct packed {
        logic [7:0]  rep;
        logic [7:0]  pcr;
        logic [15:0] cmp0;
        logic [15:0] cmpu;
        logic [15:0] cmpv;
        logic [15:0] cmpw;
    } mpu_cmpset_t;
endpackage

// >>> mpu_vec_if.sv
/*
 * Carries the gated event requests from the top to the vector grouping module.
 * Assumes one clock domain.
 */
`timescale 1ns/10ps
interface mpu_vec_if;
    logic [9:0] req;
    logic       global_mask;
    logic [2:0] vec;
    modport src (output req, output global_mask, input vec);
    modport grp (input req, input global_mask, output vec);
endinterface

// >>> mpu_vec_group.sv
/*
 * Groups the ten event requests onto three interrupt vectors.
 * Assumes requests already gated by their enable bits.
 */
`timescale 1ns/10ps
module mpu_vec_group (
    mpu_vec_if.grp vif
);
    // Vector 0: safety, speed and sampling-out events; vector 1: position events; vector 2: PWM and ratio.
    always_comb begin
        vif.vec[0] = ~vif.global_mask & (|vif.req[3:0]);
        vif.vec[1] = ~vif.global_mask & (|vif.req[6:4]);
        vif.vec[2] = ~vif.global_mask & (|vif.req[9:7]);
    end
endmodule

// >>> mpu_weight_mul.sv
/*
 * Weighted commutation compare: capture times weight over 256.
 * Assumes operands from the same clock domain.
 */
`timescale 1ns/10ps
module mpu_weight_mul (
    input  wire logic [7:0] cap_cur,
    input  wire logic [7:0] cap_prev,
    input  wire logic       use_prev,
    input  wire logic [7:0] weight,
    output logic      [7:0] result
);
    logic [15:0] product;
    always_comb begin
        product = (use_prev ? cap_prev : cap_cur) * weight;
        result  = product[15:8];
    end
endmodule

// >>> mpu_top.sv
/*
 * Motor update event, resynchronisation, start-up, low-power freeze, interrupt
 * gating and commutation timer registers.
 * Assumes a one-cycle register port master and event strobes from the motor
 * stages on the same clock; the commutation timer advances on timer_tick, as 16 bits in speed mode and 8 bits otherwise.
 */
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "mpu_defs.svh"
module mpu_top
    import mpu_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic [`MPU_ADDR_W-1:0] addr,
    input  wire logic [7:0]            wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic      [7:0]            rdata,
    input  wire logic                  halt_mode,
    input  wire logic                  global_irq_mask,
    input  wire logic                  timer_tick,
    input  wire logic                  zero_cross_ev,
    input  wire logic                  demag_ev,
    input  wire logic                  commutation_ev,
    input  wire logic                  current_limit_ev,
    input  wire logic                  emergency_stop_ev,
    input  wire logic                  sampling_out_ev,
    input  wire logic                  ratio_inc_ev,
    input  wire logic                  ratio_dec_ev,
    input  wire logic                  speed_capture_ev,
    input  wire logic                  bemf_capture_ev,
    input  wire logic [7:0]            bemf_capture_val,
    output logic      [2:0]            irq_vector,
    output logic                       update_debug,
    output logic      [`MPU_CNT_W-1:0] pwm_count,
    output logic      [15:0]           active_carrier,
    output logic      [15:0]           active_phase_u,
    output logic      [15:0]           active_phase_v,
    output logic      [15:0]           active_phase_w,
    output logic      [7:0]            active_repetition,
    output logic      [7:0]            active_prescaler
);

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        mpu_run_t        run;
        logic [7:0]      tim;
        logic [7:0]      timl;
        logic [7:0]      zprv;
        logic [7:0]      zreg;
        logic [7:0]      comp;
        logic [7:0]      dreg;
        logic [7:0]      wght;
        logic [7:0]      isr;
        logic [1:0]      isr2;
        logic [7:0]      imr;
        logic [5:0]      ctrl;
        logic            speed_block;
        mpu_cmpset_t     pre;
        mpu_cmpset_t     act;
        logic [`MPU_CNT_W-1:0] cnt;
        logic [7:0]      rep_cnt;
        logic [7:0]      rdata;
        logic [2:0]      vec;
        logic            upd_dbg;
    } mpu_state_t;

    mpu_state_t q, d;
    logic [7:0] weighted;
    logic [2:0] vec_comb;
    logic       wr_isr;
    logic       resync;
    logic       counter_wrap;
    logic       update_ev;
    logic       cke;
    logic       speed_mode;
    logic [15:0] tim_next;

    mpu_vec_if vif ();

    mpu_weight_mul u_mul (
        .cap_cur  (q.zreg),
        .cap_prev (q.zprv),
        .use_prev (q.ctrl[`MPU_CTRL_DCB]),
        .weight   (q.wght),
        .result   (weighted)
    );

    mpu_vec_group u_grp (
        .vif (vif)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Event requests, each gated by an enable; the two ratio flags share one.
    always_comb begin
        vif.global_mask = global_irq_mask;
        vif.req[0] = q.isr[`MPU_ISR_ESTOP] & q.imr[`MPU_IMR_ESTOP];
        vif.req[1] = q.isr[`MPU_ISR_CURRENT_LIMIT_ENABLE] & q.imr[`MPU_IMR_CURRENT_LIMIT_ENABLE];
        vif.req[2] = q.isr2[`MPU_ISR2_SPEED] & q.imr[`MPU_IMR_SPEED];
        vif.req[3] = q.isr2[`MPU_ISR2_SOUT] & q.ctrl[`MPU_CTRL_SOUT_EN];
        vif.req[4] = q.isr[`MPU_ISR_ZC] & q.imr[`MPU_IMR_ZC];
        vif.req[5] = q.isr[`MPU_ISR_DEMAG] & q.imr[`MPU_IMR_DEMAG];
        vif.req[6] = q.isr[`MPU_ISR_COMM] & q.imr[`MPU_IMR_COMM];
        vif.req[7] = q.isr[`MPU_ISR_UPDATE] & q.imr[`MPU_IMR_UPDATE];
        vif.req[8] = q.isr[`MPU_ISR_RINC] & q.imr[`MPU_IMR_RATIO];
        vif.req[9] = q.isr[`MPU_ISR_RDEC] & q.imr[`MPU_IMR_RATIO];
        vec_comb   = vif.vec;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d            = q;
        cke          = q.ctrl[`MPU_CTRL_CKE];
        speed_mode   = q.ctrl[`MPU_CTRL_SPEED];
        wr_isr       = wr && (addr == `MPU_OFS_ISR);
        resync       = wr_isr && (wdata == `MPU_RESYNC_VALUE);
        counter_wrap = (q.run == MPU_RUN) && (q.cnt >= q.act.cmp0[15:4]);
        update_ev    = 1'b0;
        tim_next     = {q.tim, q.timl} + 16'h0001;
        d.upd_dbg    = 1'b0;
        d.vec        = vec_comb;

        if (!halt_mode) begin
            // PWM counter and repetition.
            unique case (q.run)
                MPU_STOPPED: begin
                    d.cnt = `MPU_RESET_CNT;
                    if (cke) begin
                        d.run = MPU_START;
                    end
                end
                MPU_START: begin
                    update_ev = 1'b1;
                    d.run     = MPU_RUN;
                end
                MPU_RUN: begin
                    if (counter_wrap) begin
                        d.cnt = `MPU_RESET_CNT;
                        if (q.rep_cnt == `MPU_RESET_BYTE) begin
                            update_ev = 1'b1;
                        end else begin
                            d.rep_cnt = q.rep_cnt - 8'h01;
                        end
                    end else begin
                        d.cnt = q.cnt + 12'h001;
                    end
                end
            endcase
            if (!cke) begin
                d.run = MPU_STOPPED;
                d.cnt = `MPU_RESET_CNT;
            end
            if (resync) begin
                d.cnt     = `MPU_RESET_CNT;
                update_ev = 1'b1;
            end

            // Commutation timer counts as 8 or 16 bits.
            if (cke && timer_tick) begin
                if (speed_mode) begin
                    d.tim  = tim_next[15:8];
                    d.timl = tim_next[7:0];
                end else begin
                    d.tim = q.tim + 8'h01;
                end
            end

            // Capture sources.
            if (cke && bemf_capture_ev && !speed_mode) begin
                d.zprv = q.zreg;
                d.zreg = bemf_capture_val;
            end
            if (cke && speed_mode && speed_capture_ev && !q.speed_block) begin
                d.zreg = q.tim;
                d.zprv = q.timl;
            end
            if (cke && zero_cross_ev && q.ctrl[`MPU_CTRL_SWA] && !speed_mode) begin
                d.comp = weighted;
            end

            // Hardware sets flags; a set wins over a clear in the same cycle.
            if (wr_isr && !resync) begin
                if (q.ctrl[`MPU_CTRL_SWA]) begin
                    d.isr = q.isr & wdata;
                end else begin
                    d.isr = (q.isr & wdata) | (wdata & 8'h60);
                end
            end
            if (wr && addr == `MPU_OFS_ISR2) begin
                d.isr2 = q.isr2 & wdata[1:0];
            end
            if (cke) begin
                if (zero_cross_ev)     d.isr[`MPU_ISR_ZC]    = 1'b1;
                if (demag_ev)          d.isr[`MPU_ISR_DEMAG] = 1'b1;
                if (commutation_ev)    d.isr[`MPU_ISR_COMM]  = 1'b1;
                if (current_limit_ev)  d.isr[`MPU_ISR_CURRENT_LIMIT_ENABLE]  = 1'b1;
                if (ratio_inc_ev)      d.isr[`MPU_ISR_RINC]  = 1'b1;
                if (ratio_dec_ev)      d.isr[`MPU_ISR_RDEC]  = 1'b1;
                if (sampling_out_ev)   d.isr2[`MPU_ISR2_SOUT] = 1'b1;
                if (speed_mode && timer_tick && q.tim == q.dreg) begin
                    d.isr2[`MPU_ISR2_SPEED] = 1'b1;
                end
            end
            if (emergency_stop_ev) begin
                d.isr[`MPU_ISR_ESTOP] = 1'b1;
            end

            // Preload transfer on every update event.
            if (update_ev) begin
                d.act     = q.pre;
                d.rep_cnt = q.pre.rep;
                d.isr[`MPU_ISR_UPDATE] = 1'b1;
                d.upd_dbg = 1'b1;
            end
        end

        // Register writes.
        if (wr && !halt_mode) begin
            unique case (addr)
                `MPU_OFS_TIM:   d.tim  = wdata;
                `MPU_OFS_TIML:  d.timl = wdata;
                `MPU_OFS_ZPRV:  d.zprv = wdata;
                `MPU_OFS_ZREG:  d.zreg = wdata;
                `MPU_OFS_COMP:  d.comp = wdata;
                `MPU_OFS_DREG:  d.dreg = wdata;
                `MPU_OFS_WGHT:  d.wght = wdata;
                `MPU_OFS_IMR:   d.imr  = wdata;
                `MPU_OFS_CTRL:  d.ctrl = wdata[5:0];
                `MPU_OFS_REP:   d.pre.rep = wdata;
                `MPU_OFS_PCR:   d.pre.pcr = wdata;
                default: begin
                end
            endcase
        end
        // Compare pairs: each byte goes straight into its half of the preload register.
        if (wr && !halt_mode) begin
            unique case (addr)
                `MPU_OFS_CMP0L: d.pre.cmp0[7:0] = wdata;
                `MPU_OFS_CMPUL: d.pre.cmpu[7:0] = wdata;
                `MPU_OFS_CMPVL: d.pre.cmpv[7:0] = wdata;
                `MPU_OFS_CMPWL: d.pre.cmpw[7:0] = wdata;
                `MPU_OFS_CMP0H: d.pre.cmp0 = {wdata, q.pre.cmp0[7:0]};
                `MPU_OFS_CMPUH: d.pre.cmpu[15:8] = wdata;
                `MPU_OFS_CMPVH: d.pre.cmpv[15:8] = wdata;
                `MPU_OFS_CMPWH: d.pre.cmpw[15:8] = wdata;
                default: begin
                end
            endcase
        end

        // Read data with read side effects.
        d.rdata = `MPU_RESET_BYTE;
        if (rd) begin
            unique case (addr)
                `MPU_OFS_TIM: begin
                    d.rdata = q.tim;
                    if (speed_mode && q.ctrl[`MPU_CTRL_SWCAP] && !halt_mode) begin
                        d.zreg = q.tim;
                        d.zprv = q.timl;
                    end
                end
                `MPU_OFS_TIML:    d.rdata = q.timl;
                `MPU_OFS_ZPRV: begin
                    d.rdata       = q.zprv;
                    d.speed_block = 1'b0;
                end
                `MPU_OFS_ZREG: begin
                    d.rdata = q.zreg;
                    if (speed_mode) begin
                        d.speed_block = 1'b1;
                    end
                end
                `MPU_OFS_COMP:    d.rdata = q.comp;
                `MPU_OFS_DREG:    d.rdata = q.dreg;
                `MPU_OFS_WGHT:    d.rdata = q.wght;
                `MPU_OFS_ISR:     d.rdata = q.isr;
                `MPU_OFS_ISR2:    d.rdata = {6'h00, q.isr2};
                `MPU_OFS_IMR:     d.rdata = q.imr;
                `MPU_OFS_CTRL:    d.rdata = {2'h0, q.ctrl};
                `MPU_OFS_REP:     d.rdata = q.pre.rep;
                `MPU_OFS_PCR:     d.rdata = q.pre.pcr;
                `MPU_OFS_CMP0L:   d.rdata = q.pre.cmp0[7:0];
                `MPU_OFS_CMP0H:   d.rdata = q.pre.cmp0[15:8];
                `MPU_OFS_CMPUL:   d.rdata = q.pre.cmpu[7:0];
                `MPU_OFS_CMPUH:   d.rdata = q.pre.cmpu[15:8];
                `MPU_OFS_CMPVL:   d.rdata = q.pre.cmpv[7:0];
                `MPU_OFS_CMPVH:   d.rdata = q.pre.cmpv[15:8];
                `MPU_OFS_CMPWL:   d.rdata = q.pre.cmpw[7:0];
                `MPU_OFS_CMPWH:   d.rdata = q.pre.cmpw[15:8];
                `MPU_OFS_PWMCNTL: d.rdata = q.cnt[7:0];
                `MPU_OFS_PWMCNTH: d.rdata = {4'h0, q.cnt[11:8]};
                default:          d.rdata = `MPU_RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        rdata             = q.rdata;
        irq_vector        = q.vec;
        update_debug      = q.upd_dbg;
        pwm_count         = q.cnt;
        active_carrier    = q.act.cmp0;
        active_phase_u    = q.act.cmpu;
        active_phase_v    = q.act.cmpv;
        active_phase_w    = q.act.cmpw;
        active_repetition = q.act.rep;
        active_prescaler  = q.act.pcr;
    end
endmodule

// >>> mpu_sense_model.sv
/* Behavioural model of the inverter and rotor sensing side: event pulses
   and back-EMF captures on demand. Assumes the block's clock. */
`timescale 1ns/10ps
module mpu_sense_model (
    input  wire logic        clk,
    output logic      [10:0] ev_q,
    output logic      [7:0]  val_q
);
    initial begin
        ev_q = 11'h000;
        val_q = 8'h00;
    end

    // Bit order: tick, zc, demag, comm, curlim, estop, sout, rinc, rdec, speed, bemf.
    task automatic fire(input int unsigned idx);
        @(posedge clk);
        ev_q[idx] <= 1'b1;
        @(posedge clk);
        ev_q[idx] <= 1'b0;
    endtask

    // The value is only held while qualified, then inverted.
    task automatic capture(input logic [7:0] v);
        @(posedge clk);
        val_q <= v;
        ev_q[10] <= 1'b1;
        @(posedge clk);
        val_q <= ~v;
        ev_q[10] <= 1'b0;
    endtask
endmodule

// >>> mpu_top_chk.sv
/* Port checker for mpu_top.
   Bound to mpu_top from the testbench top file. */
`timescale 1ns/10ps
`include "mpu_defs.svh"
module mpu_top_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [4:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic        halt_mode,
    input wire logic        global_irq_mask,
    input wire logic [2:0]  irq_vector,
    input wire logic        update_debug,
    input wire logic [11:0] pwm_count,
    input wire logic [15:0] active_carrier
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic        wr_ok;
    logic        cke_q;
    logic        pum_q;
    logic [15:0] pre_q;
    assign wr_ok = wr && !halt_mode;
    always_ff @(posedge clk) begin
        if (reset) begin
            cke_q <= 1'b0;
            pum_q <= 1'b0;
            pre_q <= 16'h0000;
        end else if (wr_ok) begin
            if (addr == `MPU_OFS_CTRL) cke_q <= wdata[0];
            if (addr == `MPU_OFS_IMR) pum_q <= wdata[7];
            if (addr == `MPU_OFS_CMP0L) pre_q[7:0] <= wdata;
            if (addr == `MPU_OFS_CMP0H) pre_q[15:8] <= wdata;
        end
    end
    ////////////////////////////////////////////////////////////
    sequence s_resync;
        wr_ok && addr == `MPU_OFS_ISR && wdata == `MPU_RESYNC_VALUE;
    endsequence
    sequence s_update;
        pwm_count == 12'h000 && update_debug;
    endsequence
    a_resync_clears: assert property (s_resync |=> s_update)
        else $error("resync write did not clear counter");
    a_cke_low_zero: assert property
        (!cke_q && !$past(cke_q) && !$past(cke_q, 2) |-> pwm_count == 12'h000)
        else $error("counter moved while clock enable low");
    a_start_update: assert property
        (wr_ok && addr == `MPU_OFS_CTRL && wdata[0] && !cke_q |-> ##[1:4] update_debug)
        else $error("no update after clock enable");
    a_update_loads: assert property (update_debug |-> active_carrier == pre_q)
        else $error("update without preload transfer");
    a_update_irq: assert property
        (update_debug && pum_q && !global_irq_mask
         |-> ##[0:2] (irq_vector[2] || global_irq_mask))
        else $error("update did not raise its vector");
    a_mask_blocks: assert property
        (global_irq_mask && $past(global_irq_mask) |-> irq_vector == 3'h0)
        else $error("vector raised while masked");
    a_halt_frozen: assert property
        (halt_mode |=> $stable(pwm_count) && $stable(active_carrier))
        else $error("state changed in halt");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    a_unmapped_zero: assert property (rd && addr > 5'h16 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule

// >>> tb_mpu_top.sv
/* Self-checking testbench for mpu_top.
   Assumes the sensing model and the port checker. */
`timescale 1ns/10ps
`include "mpu_defs.svh"
module tb_mpu_top;
    logic        clk, reset, wr, rd, halt_mode, global_irq_mask;
    logic [4:0]  addr;
    logic [7:0]  wdata, rdata, cap_val;
    logic [10:0] ev;
    logic [2:0]  irq_vector;
    logic        update_debug;
    logic [11:0] pwm_count;
    logic [15:0] act_c, act_u, act_v, act_w;
    logic [7:0]  act_rep, act_pcr;
    int          err_total, checks_done;

    mpu_sense_model u_mpu_sense_model (.clk(clk), .ev_q(ev), .val_q(cap_val));
    mpu_top u_mpu_top (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .halt_mode(halt_mode), .global_irq_mask(global_irq_mask),
        .timer_tick(ev[0]), .zero_cross_ev(ev[1]), .demag_ev(ev[2]),
        .commutation_ev(ev[3]), .current_limit_ev(ev[4]),
        .emergency_stop_ev(ev[5]), .sampling_out_ev(ev[6]), .ratio_inc_ev(ev[7]),
        .ratio_dec_ev(ev[8]), .speed_capture_ev(ev[9]), .bemf_capture_ev(ev[10]),
        .bemf_capture_val(cap_val), .irq_vector(irq_vector),
        .update_debug(update_debug), .pwm_count(pwm_count), .active_carrier(act_c),
        .active_phase_u(act_u), .active_phase_v(act_v), .active_phase_w(act_w),
        .active_repetition(act_rep), .active_prescaler(act_pcr));

    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    task automatic wait_upd;
        for (int i = 0; i < 6 && update_debug !== 1'b1; i++) @(posedge clk) #1;
    endtask
    task automatic load_cmp(input logic [7:0] lo, input logic [7:0] hi);
        for (int i = 0; i < 4; i++) begin
            wreg(5'h0c + 5'(2 * i), lo);
            wreg(5'h0d + 5'(2 * i), hi + 8'(i));
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs;
        for (int i = 0; i < 7; i++) rchk(5'(i), 8'h00);
        rchk(5'h1f, 8'h00);
        for (int i = 0; i < 7; i++) wreg(5'(i), 8'ha0 + 8'(i));
        for (int i = 0; i < 7; i++) rchk(5'(i), 8'ha0 + 8'(i));
        $display("test regs done");
    endtask
    task automatic t_start;
        wreg(`MPU_OFS_IMR, 8'h84);
        load_cmp(8'hf0, 8'hfc);
        check(pwm_count, 16'h0000);
        wreg(`MPU_OFS_PCR, 8'h05);
        // Autoswitched mode, so that clearing writes cannot raise the ratio flags.
        wreg(`MPU_OFS_CTRL, 8'h03);
        wait_upd;
        check(update_debug, 16'h0001);
        check(act_c, 16'hfcf0);
        check(act_w, 16'hfff0);
        check(act_u, 16'hfdf0);
        check(act_pcr, 16'h0005);
        rchk(`MPU_OFS_ISR, 8'h80);
        check(irq_vector, 16'h0004);
        check(pwm_count != 12'h000, 16'h0001);
        wreg(`MPU_OFS_ISR, 8'h7f);
        rchk(`MPU_OFS_ISR, 8'h00);
        $display("test start done");
    endtask
    task automatic t_resync;
        u_mpu_sense_model.fire(1);
        repeat (3) @(posedge clk);
        #1 check(irq_vector, 16'h0002);
        @(posedge clk) global_irq_mask <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check(irq_vector, 16'h0000);
        @(posedge clk) global_irq_mask <= 1'b0;
        load_cmp(8'he0, 8'h80);
        wreg(`MPU_OFS_ISR, 8'hff);
        check(pwm_count, 16'h0000);
        check(update_debug, 16'h0001);
        check(act_c, 16'h80e0);
        check(act_v, 16'h82e0);
        rchk(`MPU_OFS_ISR, 8'h84);
        check(irq_vector, 16'h0006);
        wreg(`MPU_OFS_ISR, 8'h7f);
        rchk(`MPU_OFS_ISR, 8'h04);
        wreg(`MPU_OFS_IMR, 8'h04);
        wreg(`MPU_OFS_ISR, 8'hff);
        repeat (2) @(posedge clk);
        #1 check(irq_vector, 16'h0002);
        wreg(`MPU_OFS_ISR, 8'h00);
        wreg(`MPU_OFS_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        #1 check(pwm_count, 16'h0000);
        $display("test resync done");
    endtask
    task automatic t_halt;
        @(posedge clk) halt_mode <= 1'b1;
        wreg(`MPU_OFS_WGHT, 8'h55);
        rchk(`MPU_OFS_WGHT, 8'ha6);
        @(posedge clk) halt_mode <= 1'b0;
        $display("test halt done");
    endtask
    task automatic t_weight;
        wreg(`MPU_OFS_CTRL, 8'h03);
        wreg(`MPU_OFS_WGHT, 8'hff);
        u_mpu_sense_model.capture(8'hc8);
        u_mpu_sense_model.capture(8'h40);
        rchk(`MPU_OFS_ZREG, 8'h40);
        rchk(`MPU_OFS_ZPRV, 8'hc8);
        u_mpu_sense_model.fire(1);
        rchk(`MPU_OFS_COMP, 8'h3f);
        wreg(`MPU_OFS_CTRL, 8'h07);
        wreg(`MPU_OFS_WGHT, 8'h80);
        u_mpu_sense_model.fire(1);
        rchk(`MPU_OFS_COMP, 8'h64);
        wreg(`MPU_OFS_CTRL, 8'h00);
        $display("test weight done");
    endtask
    task automatic t_speed;
        wreg(`MPU_OFS_CTRL, 8'h19);
        wreg(`MPU_OFS_TIM, 8'h00);
        wreg(`MPU_OFS_TIML, 8'hff);
        u_mpu_sense_model.fire(0);
        rchk(`MPU_OFS_TIML, 8'h00);
        rchk(`MPU_OFS_TIM, 8'h01);
        rchk(`MPU_OFS_ZREG, 8'h01);
        wreg(`MPU_OFS_TIML, 8'h77);
        u_mpu_sense_model.fire(9);
        rchk(`MPU_OFS_ZREG, 8'h01);
        rchk(`MPU_OFS_ZPRV, 8'h00);
        u_mpu_sense_model.fire(9);
        rchk(`MPU_OFS_ZPRV, 8'h77);
        wreg(`MPU_OFS_DREG, 8'h01);
        u_mpu_sense_model.fire(0);
        rchk(`MPU_OFS_ISR2, 8'h01);
        $display("test speed done");
    endtask
    task automatic t_events;
        wreg(`MPU_OFS_CTRL, 8'h21);
        wreg(`MPU_OFS_IMR, 8'h18);
        wreg(`MPU_OFS_ISR2, 8'h00);
        wreg(`MPU_OFS_ISR, 8'h00);
        for (int i = 2; i < 8; i++) begin
            if (i != 6) u_mpu_sense_model.fire(i);
        end
        rchk(`MPU_OFS_ISR, 8'h5b);
        check(irq_vector, 16'h0001);
        wreg(`MPU_OFS_ISR, 8'h00);
        // Switched mode: software raises each ratio flag whose bit it writes as 1.
        wreg(`MPU_OFS_ISR, 8'hbf);
        rchk(`MPU_OFS_ISR, 8'h20);
        check(irq_vector, 16'h0000);
        u_mpu_sense_model.fire(8);
        u_mpu_sense_model.fire(6);
        rchk(`MPU_OFS_ISR2, 8'h02);
        check(irq_vector, 16'h0001);
        $display("test events done");
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        {wr, rd, halt_mode, global_irq_mask} = 4'h0;
        addr = 5'h00;
        wdata = 8'h00;
        err_total = 0;
        checks_done = 0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        t_start;
        t_resync;
        t_halt;
        t_weight;
        t_speed;
        t_events;
        end_of_test;
    end
    initial begin
        #(25 * 20000);
        err_total++;
        end_of_test;
    end
endmodule

bind mpu_top mpu_top_chk u_mpu_top_chk (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .halt_mode(halt_mode), .global_irq_mask(global_irq_mask),
    .irq_vector(irq_vector), .update_debug(update_debug), .pwm_count(pwm_count),
    .active_carrier(active_carrier));
